// ==== interrupt_arbiter.sv ====
`timescale 1ns/1ps
module interrupt_arbiter #(
  parameter int N_SRC = irq_arb_pkg::NUM_SRC
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [81:0] irq_req,
  input wire logic [81:0] irq_enable,
  input wire logic [81:0][1:0] priority_level_regs,
  input wire logic [13:0] vector_base,
  input wire irq_arb_pkg::fast_cfg_t fast_match_zero,
  input wire irq_arb_pkg::fast_cfg_t fast_match_one,
  input wire logic [1:0] core_status_mask,
  input wire logic ext_irq_a_pin_n,
  input wire logic ext_irq_b_pin_n,
  input wire logic [1:0] ext_edge_sel,
  input wire logic [1:0] ext_edge_clear,
  input wire logic wait_req,
  input wire logic stop_req,
  output logic irq_valid,
  output logic [20:0] vector_addr,
  output logic [6:0] vector_num,
  output logic fast_sel,
  output logic [1:0] current_level_code,
  output logic wake_request,
  output irq_arb_pkg::mode_t mode
);
  // ==========================================
  // Parameter check
  if (N_SRC != irq_arb_pkg::NUM_SRC || N_SRC > (1 << irq_arb_pkg::VEC_W))
  begin : g_bad_src
    $error("Source count not supported");
  end

  irq_arb_pkg::arb_state_t s;
  irq_arb_pkg::arb_state_t next_s;
  logic [81:0] act;
  logic [81:0] src_req;
  logic [81:0] wake_ok;
  logic [81:0][1:0] lvl;
  logic [1:0] pin_low;
  logic [1:0] pin_req;
  logic found;
  logic [1:0] best_lvl;
  logic [6:0] best_num;
  logic hit_zero;
  logic hit_one;

  // ==========================================
  // Source conditioning
  always_comb
  begin
    for (int p = 0; p < 2; p++)
    begin
      pin_low[p] = ~s.pin_sync[p][1];
      // Edge mode only in functional mode
      if (s.mode != irq_arb_pkg::MODE_FUNC || !ext_edge_sel[p])
      begin
        pin_req[p] = pin_low[p];
      end
      else
      begin
        pin_req[p] = s.pin_edge[p];
      end
    end
    src_req = irq_req;
    src_req[irq_arb_pkg::EXT_A_SRC] = pin_req[0];
    src_req[irq_arb_pkg::EXT_B_SRC] = pin_req[1];
    for (int i = 0; i < 82; i++)
    begin
      // Fixed sources ignore their level field
      lvl[i] = (i < irq_arb_pkg::FIXED_CNT) ? irq_arb_pkg::FIXED_LEVEL
        : priority_level_regs[i];
      wake_ok[i] = (7'(i) == irq_arb_pkg::EXT_A_SRC)
        || (7'(i) == irq_arb_pkg::EXT_B_SRC)
        || (7'(i) == irq_arb_pkg::CAN_WAKE_SRC);
    end
    // Low power uses the enables frozen at entry
    act = src_req & ((s.mode == irq_arb_pkg::MODE_FUNC) ? irq_enable
      : s.enable_snap);
  end

  // ==========================================
  // Arbitration: level first, then lowest number
  always_comb
  begin
    found = 1'b0;
    best_lvl = 2'h0;
    best_num = 7'h00;
    for (int i = 81; i >= 0; i--)
    begin
      if (act[i] && (!found || lvl[i] >= best_lvl))
      begin
        found = 1'b1;
        best_lvl = lvl[i];
        best_num = 7'(i);
      end
    end
    hit_zero = best_lvl == irq_arb_pkg::FAST_LEVEL
      && best_num == fast_match_zero.match;
    hit_one = best_lvl == irq_arb_pkg::FAST_LEVEL
      && best_num == fast_match_one.match;
  end

  // ==========================================
  // Next state
  always_comb
  begin
    next_s = s;
    for (int p = 0; p < 2; p++)
    begin
      next_s.pin_prev[p] = s.pin_sync[p][1];
      // Falling edge sets, clear loses to a new edge
      if (s.pin_prev[p] && !s.pin_sync[p][1])
      begin
        next_s.pin_edge[p] = 1'b1;
      end
      else if (ext_edge_clear[p])
      begin
        next_s.pin_edge[p] = 1'b0;
      end
    end
    next_s.pin_sync[0] = {s.pin_sync[0][0], ext_irq_a_pin_n};
    next_s.pin_sync[1] = {s.pin_sync[1][0], ext_irq_b_pin_n};
    // Low-power entry and exit
    case (s.mode)
      irq_arb_pkg::MODE_FUNC:
      begin
        if (stop_req || wait_req)
        begin
          next_s.enable_snap = irq_enable;
          next_s.mode = stop_req ? irq_arb_pkg::MODE_STOP
            : irq_arb_pkg::MODE_WAIT;
        end
      end
      irq_arb_pkg::MODE_WAIT:
      begin
        if (!wait_req)
        begin
          next_s.mode = irq_arb_pkg::MODE_FUNC;
        end
      end
      irq_arb_pkg::MODE_STOP:
      begin
        if (!stop_req)
        begin
          next_s.mode = irq_arb_pkg::MODE_FUNC;
        end
      end
      default:
      begin
        next_s.mode = irq_arb_pkg::MODE_FUNC;
      end
    endcase
    // Restart request to the system integration unit
    if (s.mode == irq_arb_pkg::MODE_STOP)
    begin
      next_s.wake = |(act & wake_ok);
    end
    else
    begin
      next_s.wake = (s.mode == irq_arb_pkg::MODE_WAIT) && (|act);
    end
    // Presented interrupt
    next_s.valid = found && best_lvl >= core_status_mask
      && s.mode == irq_arb_pkg::MODE_FUNC;
    next_s.lvl = best_lvl;
    next_s.num = best_num;
    next_s.fast = hit_zero || hit_one;
    if (hit_zero)
    begin
      next_s.addr = {fast_match_zero.high, fast_match_zero.low};
    end
    else if (hit_one)
    begin
      next_s.addr = {fast_match_one.high, fast_match_one.low};
    end
    else if (found)
    begin
      next_s.addr = {vector_base, best_num};
    end
    // Level code of the presented interrupt
    if (!next_s.valid)
    begin
      next_s.code = irq_arb_pkg::CODE_NONE;
    end
    else if (best_lvl == 2'h0)
    begin
      next_s.code = irq_arb_pkg::CODE_P0;
    end
    else if (best_lvl == 2'h1)
    begin
      next_s.code = irq_arb_pkg::CODE_P1;
    end
    else
    begin
      next_s.code = irq_arb_pkg::CODE_P23;
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s <= '0;
      s.pin_sync <= 4'hF;
      s.pin_prev <= 2'h3;
      s.mode <= irq_arb_pkg::MODE_FUNC;
      s.addr <= irq_arb_pkg::RESET_FETCH_ADDR;
    end
    else if (clk_en)
    begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign irq_valid = s.valid;
  assign vector_addr = s.addr;
  assign vector_num = s.num;
  assign fast_sel = s.fast;
  assign current_level_code = s.code;
  assign wake_request = s.wake;
  assign mode = s.mode;

  // ==========================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  mask_gate_a: assert property ($past(clk_en) && irq_valid
    |-> s.lvl >= $past(core_status_mask))
    else $error("Masked level presented");
  level_code_a: assert property (irq_valid && s.lvl == 2'h0
    |-> current_level_code == 2'h1)
    else $error("Wrong level code for level 0");
  fast_level_a: assert property (irq_valid && fast_sel
    |-> s.lvl == irq_arb_pkg::FAST_LEVEL)
    else $error("Fast vector at wrong level");
  normal_addr_a: assert property (irq_valid && !fast_sel
    |-> vector_addr == {$past(vector_base), vector_num}
    || !$past(clk_en))
    else $error("Normal vector address wrong");
  reset_addr_a: assert property ($past(rst) |-> !irq_valid
    && vector_addr == irq_arb_pkg::RESET_FETCH_ADDR)
    else $error("Reset fetch address missing");
  func_mode_a: assert property ($past(rst)
    |-> mode == irq_arb_pkg::MODE_FUNC)
    else $error("Not functional after reset");
  winner_active_a: assert property ($past(clk_en) && irq_valid
    |-> |($past(act) & (82'h1 << vector_num)))
    else $error("Presented source not active");
  no_wake_func_a: assert property (clk_en
    && mode == irq_arb_pkg::MODE_FUNC |=> !wake_request)
    else $error("Wake request in functional mode");
  stop_wake_a: assert property (clk_en && mode == irq_arb_pkg::MODE_STOP
    && !(|(act & wake_ok)) |=> !wake_request)
    else $error("Stop wake from clocked source");

  fast_cov: cover property (irq_valid && fast_sel);
  nest_cov: cover property (irq_valid && core_status_mask == 2'h3);
  stop_wake_cov: cover property (mode == irq_arb_pkg::MODE_STOP
    && wake_request);
endmodule : interrupt_arbiter

// ==== irq_arb_pkg.sv ====
package irq_arb_pkg;
  // ==========================================
  // Widths
  localparam int NUM_SRC = 82;
  localparam int VEC_W = 7;
  localparam int BASE_W = 14;
  localparam int LOW_W = 16;
  localparam int HIGH_W = 5;
  localparam int ADDR_W = BASE_W + VEC_W;
  localparam int FIXED_CNT = 2;
  // ==========================================
  // Levels, codes and fixed values
  localparam logic [1:0] FAST_LEVEL = 2'h2;
  localparam logic [1:0] FIXED_LEVEL = 2'h3;
  localparam logic [1:0] CODE_NONE = 2'h0;
  localparam logic [1:0] CODE_P0 = 2'h1;
  localparam logic [1:0] CODE_P1 = 2'h2;
  localparam logic [1:0] CODE_P23 = 2'h3;
  localparam logic [6:0] EXT_A_SRC = 7'h10;
  localparam logic [6:0] EXT_B_SRC = 7'h11;
  localparam logic [6:0] CAN_WAKE_SRC = 7'h1B;
  localparam logic [20:0] RESET_FETCH_ADDR = 21'h000000;
  // ==========================================
  // Types
  typedef enum logic [2:0]
  {
    MODE_FUNC = 3'h1,
    MODE_WAIT = 3'h2,
    MODE_STOP = 3'h4
  } mode_t;
  typedef struct packed
  {
    logic [6:0] match;
    logic [4:0] high;
    logic [15:0] low;
  } fast_cfg_t;
  typedef struct packed
  {
    logic [1:0][1:0] pin_sync;
    logic [1:0] pin_prev;
    logic [1:0] pin_edge;
    mode_t mode;
    logic [81:0] enable_snap;
    logic valid;
    logic [1:0] lvl;
    logic [6:0] num;
    logic fast;
    logic [20:0] addr;
    logic [1:0] code;
    logic wake;
  } arb_state_t;
endpackage : irq_arb_pkg

// ==== core_model.sv ====
`timescale 1ns/1ps
// ==========================================
// Core and clock unit stand-in
module core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] mask_in,
  input wire logic wake_request,
  input wire logic irq_valid,
  input wire logic fast_sel,
  input wire logic fetch_is_jump,
  output logic [1:0] core_status_mask,
  output logic clk_en,
  output logic fast_handling
);
  // Core mask follows the handler's level at once
  assign core_status_mask = rst ? 2'h0 : mask_in;
  // Clock unit keeps clocks on so restart requests stay visible
  assign clk_en = 1'b1;
  // Fast handling starts only when the fetched word is no jump
  assign fast_handling = irq_valid && fast_sel && !fetch_is_jump;
endmodule : core_model

// ==== test_priority_interrupt_controller.sv ====
`timescale 1ns/1ps
// ==========================================
// Arbiter bench with a reference model
module test_priority_interrupt_controller;
  logic clk = 0, rst = 1, wait_req = 0, stop_req = 0, pa = 1, pb = 1;
  logic clk_en, wake_request, irq_valid, fast_sel;
  logic fetch_is_jump = 0, fast_handling;
  logic [1:0] mask_in = 0, edge_sel = 0, edge_clr = 0;
  logic [1:0] current_level_code, core_status_mask;
  logic [81:0] req = 0, en = 0;
  logic [81:0][1:0] lvl = 0;
  logic [13:0] base = 0;
  irq_arb_pkg::fast_cfg_t f0 = 0, f1 = 0;
  logic [20:0] vector_addr;
  logic [6:0] vector_num;
  irq_arb_pkg::mode_t mode;
  int err_count = 0, num_checks = 0, seed = 32'h7c2ec7f0;
  int win, wl, i, l, k;
  logic fast;
  core_model partner (.clk(clk), .rst(rst), .mask_in(mask_in),
    .wake_request(wake_request), .irq_valid(irq_valid),
    .fast_sel(fast_sel), .fetch_is_jump(fetch_is_jump),
    .core_status_mask(core_status_mask), .clk_en(clk_en),
    .fast_handling(fast_handling));
  interrupt_arbiter uut (.clk(clk), .rst(rst), .clk_en(clk_en),
    .irq_req(req), .irq_enable(en), .priority_level_regs(lvl),
    .vector_base(base), .fast_match_zero(f0), .fast_match_one(f1),
    .core_status_mask(core_status_mask), .ext_irq_a_pin_n(pa),
    .ext_irq_b_pin_n(pb), .ext_edge_sel(edge_sel),
    .ext_edge_clear(edge_clr), .wait_req(wait_req), .stop_req(stop_req),
    .irq_valid(irq_valid), .vector_addr(vector_addr),
    .vector_num(vector_num), .fast_sel(fast_sel),
    .current_level_code(current_level_code),
    .wake_request(wake_request), .mode(mode));
  // Clock and watchdog
  initial forever #5 clk = ~clk;
  initial
  begin
    #50us;
    err_count++;
    close_out();
  end
  // ==========================================
  // Comparison, verdict and model
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task close_out();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  task model();
    win = -1;
    wl = -1;
    for (i = 0; i < 82; i++)
    begin
      l = (i < 2) ? 3 : int'(lvl[i]);
      if (req[i] && en[i] && i != 16 && i != 17 && l >= mask_in && l > wl)
      begin
        win = i;
        wl = l;
      end
    end
  endtask : model
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // ==========================================
  // Main sequence
  initial
  begin
    cyc(6);
    rst = 0;
    cyc(1);
    check(vector_addr, irq_arb_pkg::RESET_FETCH_ADDR);
    check(mode, irq_arb_pkg::MODE_FUNC);
    $display("test reset done");
    repeat (300)
    begin
      for (i = 0; i < 82; i++)
      begin
        req[i] = ($random(seed) % 4) == 0;
        en[i] = 1'($random(seed));
        lvl[i] = 2'($random(seed));
      end
      mask_in = 2'($random(seed));
      base = 14'($random(seed));
      f0 = 28'($random(seed));
      f1 = 28'($random(seed));
      model();
      k = $random(seed);
      if (win >= 0 && k[0]) f0.match = 7'(win);
      if (win >= 0 && k[1]) f1.match = 7'(win);
      fetch_is_jump = k[2];
      cyc(1);
      check(irq_valid, win >= 0);
      if (win >= 0)
      begin
        fast = wl == 2 && (f0.match == win || f1.match == win);
        check(vector_num, win);
        check(fast_sel, fast);
        check(vector_addr, !fast ? {base, 7'(win)} : f0.match == win ?
          {f0.high, f0.low} : {f1.high, f1.low});
        check(current_level_code, wl == 0 ? 1 : wl == 1 ? 2 : 3);
      end
      else
        check(current_level_code, 0);
      check(fast_handling, win >= 0 && fast && !k[2]);
      cyc(1);
    end
    $display("test arbitration done");
    req = 0;
    en = 0;
    mask_in = 0;
    req[5] = 1;
    req[27] = 1;
    en[5] = 1;
    en[16] = 1;
    edge_sel = 2'h3;
    wait_req = 1;
    cyc(3);
    check(mode, irq_arb_pkg::MODE_WAIT);
    check(wake_request, 1);
    check(irq_valid, 0);
    wait_req = 0;
    cyc(2);
    stop_req = 1;
    cyc(3);
    check(mode, irq_arb_pkg::MODE_STOP);
    check(wake_request, 0);
    en[27] = 1;
    cyc(3);
    check(wake_request, 0);
    pa = 0;
    cyc(6);
    check(wake_request, 1);
    $display("test low power done");
    stop_req = 0;
    pa = 1;
    req = 0;
    en = 0;
    en[16] = 1;
    lvl[16] = 2'h1;
    edge_sel = 2'h1;
    // Drop the edge latched while stopped before the edge test
    edge_clr = 2'h3;
    cyc(1);
    edge_clr = 2'h0;
    cyc(5);
    check(irq_valid, 0);
    pa = 0;
    cyc(6);
    pa = 1;
    cyc(6);
    check(irq_valid, 1);
    check(vector_num, irq_arb_pkg::EXT_A_SRC);
    edge_clr = 2'h1;
    cyc(1);
    edge_clr = 2'h0;
    cyc(3);
    check(irq_valid, 0);
    $display("test edge pin done");
    close_out();
  end
endmodule : test_priority_interrupt_controller
